// >>> src/select_decoder_cfg.svh
`ifndef SELECT_DECODER_CFG_SVH
`define SELECT_DECODER_CFG_SVH

// address bit positions used by the decoder
`define SEL_BIT_ROM_AREA 15
`define SEL_BIT_ROM_PICK 10
`define SEL_BIT_RAM_LO 7
`define SEL_BIT_RAM_HI 8
`define SEL_BIT_SERIAL 10
`define SEL_BIT_PAR0 11
`define SEL_BIT_PAR1 12

// base addresses of each device window
`define SEL_BASE_ROM0 16'h8000
`define SEL_BASE_ROM1 16'h8400
`define SEL_BASE_RAM0 16'h0000
`define SEL_BASE_RAM1 16'h0080
`define SEL_BASE_RAM2 16'h0100
`define SEL_BASE_SERIAL 16'h0580
`define SEL_BASE_PAR0 16'h0980
`define SEL_BASE_PAR1 16'h1180

// start-up vector addresses
`define SEL_VEC_HI 16'hfffe
`define SEL_VEC_LO 16'hffff

// instruction length bounds in machine cycles
`define SEL_INSTR_MIN_CYC 2
`define SEL_INSTR_MAX_CYC 12

// all selects low after reset
`define SEL_RESET_VAL 8'h00

`endif

// >>> src/select_decoder_pkg.sv
package select_decoder_pkg;

    // processor bus cycle seen by the decoder
    typedef struct packed {
        logic [15:0] addr;
        logic valid_address_flag;
        logic rd_wr;
        logic phase_two;
        logic tristate_request;
        logic sleep_until_irq_op;
    } bus_s;

    // one select per device, active high
    typedef struct packed {
        logic rom0;
        logic rom1;
        logic ram0;
        logic ram1;
        logic ram2;
        logic serial_adapter;
        logic parallel_adapter0;
        logic parallel_adapter1;
    } sel_s;

    typedef enum logic [1:0] {
        BUS_IDLE,
        BUS_READ,
        BUS_WRITE
    } cyc_e;

endpackage

// >>> src/select_decode_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "select_decoder_cfg.svh"

module select_decode_core
(
    input wire select_decoder_pkg::bus_s i_bus,
    output var select_decoder_pkg::sel_s o_sel
);

    logic hi;
    logic flag;

    // pure address decode, no state
    always_comb
    begin
        hi = i_bus.addr[`SEL_BIT_ROM_AREA];
        flag = i_bus.valid_address_flag;
        // rom area only with the top bit high; a10 picks the half
        o_sel.rom0 = hi & flag & ~i_bus.addr[`SEL_BIT_ROM_PICK];
        o_sel.rom1 = hi & flag & i_bus.addr[`SEL_BIT_ROM_PICK];
        // rams need a7/a8 and an inverted top bit
        o_sel.ram0 = ~hi & flag & ~i_bus.addr[`SEL_BIT_RAM_LO] & ~i_bus.addr[`SEL_BIT_RAM_HI];
        o_sel.ram1 = ~hi & flag & i_bus.addr[`SEL_BIT_RAM_LO] & ~i_bus.addr[`SEL_BIT_RAM_HI];
        o_sel.ram2 = ~hi & flag & ~i_bus.addr[`SEL_BIT_RAM_LO] & i_bus.addr[`SEL_BIT_RAM_HI];
        // adapters gated by the valid-address flag so idle cycles never clear interrupts
        o_sel.serial_adapter = ~hi & flag & i_bus.addr[`SEL_BIT_SERIAL];
        o_sel.parallel_adapter0 = ~hi & flag & i_bus.addr[`SEL_BIT_PAR0];
        o_sel.parallel_adapter1 = ~hi & flag & i_bus.addr[`SEL_BIT_PAR1];
    end

endmodule
`default_nettype wire

// >>> src/select_decoder.sv
// Function
// - rom region only when a15 high
// - a10 picks rom half, halves alternate every 1k
// - rams picked by a7 a8, address flag
// - inverted a15 qualifies every non-rom select
// - serial adapter on a10 at 0580
// - parallel adapters on a11, a12
// - all peripheral selects gated by flag
// - memory selects anded with flag too
// - read/write held high on idle cycles
// - start-up vectors fffe, ffff land in rom
// - tolerate any bus mix, 2..12 cycles
// - bus drive follows phase two
// - data drive drops after phase two
// - direct page spans first two rams
`timescale 1ns/1ps
`default_nettype none
`include "select_decoder_cfg.svh"

module select_decoder
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire select_decoder_pkg::bus_s i_bus,
    output logic [7:0] o_sel,
    output logic o_rd_wr,
    output logic o_bus_drive_enable,
    output logic o_cyc_illegal
);

    select_decoder_pkg::sel_s comb_sel;
    select_decoder_pkg::sel_s sel_r;
    select_decoder_pkg::sel_s sel_nxt;
    logic rd_wr_r;
    logic rd_wr_nxt;
    logic drive_r;
    logic drive_nxt;
    logic illegal_r;
    logic illegal_nxt;
    logic floating;

    select_decode_core u_core
    (
        .i_bus(i_bus),
        .o_sel(comb_sel)
    );

    // next values; floating bus during sleep or tristate blocks every select
    always_comb
    begin
        floating = i_bus.tristate_request | i_bus.sleep_until_irq_op;
        sel_nxt = floating ? select_decoder_pkg::sel_s'(`SEL_RESET_VAL) : comb_sel;
        // idle cycles report read so no false write reaches memory
        rd_wr_nxt = i_bus.valid_address_flag & ~floating ? i_bus.rd_wr : 1'b1;
        // drive only after phase two was sampled high, so it drops one cycle after its trailing edge
        drive_nxt = i_bus.phase_two & ~i_bus.rd_wr & ~floating;
        // more than one select would mean a decode overlap
        illegal_nxt = ($countones(sel_nxt) > 1);
    end

    // registered outputs give glitch-free selects at one cycle latency
    // every edge decodes afresh, so any mix of bus and idle cycles is fine
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sel_r <= select_decoder_pkg::sel_s'(`SEL_RESET_VAL);
            rd_wr_r <= 1'b1;
            drive_r <= 1'b0;
            illegal_r <= 1'b0;
        end
        else
        begin
            sel_r <= sel_nxt;
            rd_wr_r <= rd_wr_nxt;
            drive_r <= drive_nxt;
            illegal_r <= illegal_nxt;
        end
    end

    assign o_sel = sel_r;
    assign o_rd_wr = rd_wr_r;
    assign o_bus_drive_enable = drive_r;
    assign o_cyc_illegal = illegal_r;

    // checks on the decoded selects, read/write and bus drive
    rom_area_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (sel_r.rom0 | sel_r.rom1) |-> $past(i_bus.addr[15]))
        else $error("rom select without a15");
    rom_pick_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        sel_r.rom1 |-> $past(i_bus.addr[10]))
        else $error("rom half mismatch");
    ram_pick_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        sel_r.ram2 |-> $past(i_bus.addr[8]) && !$past(i_bus.addr[7]))
        else $error("third ram select wrong");
    low_area_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $past(i_bus.addr[15]) |-> !(sel_r.ram0 | sel_r.serial_adapter | sel_r.parallel_adapter0))
        else $error("low device selected in rom area");
    serial_sel_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        sel_r.serial_adapter |-> $past(i_bus.addr[10]))
        else $error("serial select without a10");
    par_sel_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        sel_r.parallel_adapter1 |-> $past(i_bus.addr[12]))
        else $error("parallel select without a12");
    vma_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !$past(i_bus.valid_address_flag) |-> (sel_r == '0))
        else $error("select without valid address");
    float_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $past(i_bus.tristate_request) |-> (sel_r == '0) && o_rd_wr)
        else $error("select while bus floats");
    idle_read_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !$past(i_bus.valid_address_flag) |-> o_rd_wr)
        else $error("write on idle cycle");
    drive_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        !$past(i_bus.phase_two) |-> !o_bus_drive_enable)
        else $error("drive past phase two");
    vector_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $past(i_nrst) && ($past(i_bus.addr) == `SEL_VEC_HI) && $past(i_bus.valid_address_flag)
        && !$past(i_bus.tristate_request) && !$past(i_bus.sleep_until_irq_op) |-> sel_r.rom1)
        else $error("vector not in rom");

    // second start-up fetch must also land in the upper rom
    vector_lo_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $past(i_nrst) && ($past(i_bus.addr) == `SEL_VEC_LO) && $past(i_bus.valid_address_flag)
        && !$past(i_bus.tristate_request) && !$past(i_bus.sleep_until_irq_op) |-> sel_r.rom1)
        else $error("second vector not in rom");

    // lower rom half only with a10 low
    rom0_pick_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        sel_r.rom0 |-> !$past(i_bus.addr[10]))
        else $error("lower rom half mismatch");

    // a valid fetch in the rom area must select exactly one rom
    rom_decode_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $past(i_nrst) && $past(i_bus.addr[15]) && $past(i_bus.valid_address_flag)
        && !$past(i_bus.tristate_request) && !$past(i_bus.sleep_until_irq_op)
        |-> (sel_r.rom0 ^ sel_r.rom1))
        else $error("rom area fetch without rom select");

    // first ram needs a7 and a8 both low in the low area
    ram0_pick_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        sel_r.ram0 |-> !$past(i_bus.addr[7]) && !$past(i_bus.addr[8]) && !$past(i_bus.addr[15]))
        else $error("first ram select wrong");

    // second ram continues the direct page right after the first
    ram1_pick_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        sel_r.ram1 |-> $past(i_bus.addr[7]) && !$past(i_bus.addr[8]))
        else $error("second ram select wrong");

    // memory selects never rise without a valid address
    ram_flag_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (sel_r.ram0 | sel_r.ram1 | sel_r.ram2 | sel_r.rom0 | sel_r.rom1)
        |-> $past(i_bus.valid_address_flag))
        else $error("memory select without valid address");

    // first parallel adapter follows a11 in the low area
    par0_sel_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        sel_r.parallel_adapter0 |-> $past(i_bus.addr[11]) && !$past(i_bus.addr[15]))
        else $error("parallel select without a11");

    // remaining low-area selects stay off in the rom area
    low_rest_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (sel_r.ram1 | sel_r.ram2 | sel_r.parallel_adapter1) |-> !$past(i_bus.addr[15]))
        else $error("low device selected in rom area");

    // adapter selects need the valid-address flag, so idle reads stay harmless
    adapter_flag_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (sel_r.serial_adapter | sel_r.parallel_adapter0 | sel_r.parallel_adapter1)
        |-> $past(i_bus.valid_address_flag))
        else $error("adapter select without valid address");

    // a10 alone in the low area with rams enabled is a decode overlap
    overlap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $past(i_nrst) && $past(i_bus.valid_address_flag) && !$past(i_bus.addr[15])
        && $past(i_bus.addr[10]) && !$past(i_bus.addr[7]) && !$past(i_bus.addr[8])
        && !$past(i_bus.tristate_request) && !$past(i_bus.sleep_until_irq_op) |-> o_cyc_illegal)
        else $error("overlap not flagged");

    // a write in phase two must drive the data bus
    drive_on_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $past(i_nrst) && $past(i_bus.phase_two) && !$past(i_bus.rd_wr)
        && !$past(i_bus.tristate_request) && !$past(i_bus.sleep_until_irq_op) |-> o_bus_drive_enable)
        else $error("no drive on write");

    // a valid cycle passes read/write through unchanged
    rd_wr_pass_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $past(i_nrst) && $past(i_bus.valid_address_flag)
        && !$past(i_bus.tristate_request) && !$past(i_bus.sleep_until_irq_op)
        |-> (o_rd_wr == $past(i_bus.rd_wr)))
        else $error("read/write not passed");

    // sleeping processor floats the bus, so nothing may be selected or driven
    sleep_gate_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $past(i_bus.sleep_until_irq_op) |-> (sel_r == '0) && o_rd_wr && !o_bus_drive_enable)
        else $error("select while processor sleeps");

    rom_read_c: cover property (@(posedge i_clk) disable iff (!i_nrst) sel_r.rom0 ##1 sel_r.rom1);
    ram_c: cover property (@(posedge i_clk) disable iff (!i_nrst) sel_r.ram1);
    serial_c: cover property (@(posedge i_clk) disable iff (!i_nrst) sel_r.serial_adapter ##1 sel_r == '0);
    write_c: cover property (@(posedge i_clk) disable iff (!i_nrst) o_bus_drive_enable);
    overlap_c: cover property (@(posedge i_clk) disable iff (!i_nrst) o_cyc_illegal);

endmodule
`default_nettype wire

// >>> tb/select_partner.sv
`timescale 1ns/1ps
`default_nettype none
// far-side devices: counts the accesses that a device really takes
module select_partner
(
    input wire logic i_clk,
    input wire logic [7:0] i_sel,
    input wire logic i_rd_wr,
    output logic [15:0] o_hits
);
    logic [15:0] hits_r = 16'h0000;
    logic [1:0] cs_first;
    logic [1:0] cs_second_n;
    logic [1:0] cs_third;
    logic [1:0] rom_take;
    // rom pins: first and third active-true, second active-false; a write blocks the rom
    assign cs_first = i_sel[7:6];
    assign cs_second_n = {2{~i_rd_wr}};
    assign cs_third = 2'b11;
    assign rom_take = cs_first & ~cs_second_n & cs_third;
    always @(posedge i_clk)
        if ((|i_sel[5:0]) || (|rom_take))
            hits_r <= hits_r + 16'h0001;
    assign o_hits = hits_r;
endmodule
`default_nettype wire

// >>> tb/select_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module select_decoder_tb;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic chk_en = 1'b0;
    select_decoder_pkg::bus_s bus = '0;
    logic [7:0] o_sel;
    logic o_rd_wr;
    logic o_drive;
    logic o_ill;
    logic [10:0] exp_r;
    logic [15:0] hits;
    logic [31:0] rng = 32'h0000004e;
    logic [31:0] r;
    int fails = 0;
    int checked = 0;
    int hits_m = 0;
    logic [15:0] tbl [11] = '{16'h8000, 16'h8400, 16'hfffe, 16'hffff, 16'h0000, 16'h0080,
                              16'h0100, 16'h0580, 16'h0980, 16'h1180, 16'h0400};
    select_decoder dut_u (.i_clk(i_clk), .i_nrst(i_nrst), .i_bus(bus), .o_sel(o_sel), .o_rd_wr(o_rd_wr),
                          .o_bus_drive_enable(o_drive), .o_cyc_illegal(o_ill));
    select_partner part_u (.i_clk(i_clk), .i_sel(o_sel), .i_rd_wr(o_rd_wr), .o_hits(hits));
    always #12.5 i_clk = ~i_clk;
    function automatic logic [31:0] xr();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction
    // reference decode: {selects, rd_wr, drive, overlap}
    function automatic logic [10:0] model(select_decoder_pkg::bus_s b);
        logic flt;
        logic v;
        logic [7:0] s;
        flt = b.tristate_request | b.sleep_until_irq_op;
        v = b.valid_address_flag & ~flt;
        s = {v & b.addr[15] & ~b.addr[10], v & b.addr[15] & b.addr[10],
             v & ~b.addr[15] & ~b.addr[7] & ~b.addr[8], v & ~b.addr[15] & b.addr[7] & ~b.addr[8],
             v & ~b.addr[15] & ~b.addr[7] & b.addr[8], v & ~b.addr[15] & b.addr[10],
             v & ~b.addr[15] & b.addr[11], v & ~b.addr[15] & b.addr[12]};
        return {s, v ? b.rd_wr : 1'b1, b.phase_two & ~b.rd_wr & ~flt, $countones(s) > 1};
    endfunction
    task automatic chk_sel(input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %0t value %h want %h", $time, g, e);
        end
    endtask
    task automatic chk_bit(input logic e, input logic g, input string n);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %0t %s is %b", $time, n, g);
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // one-cycle latency reference, cleared like the design's registers
    always @(posedge i_clk or negedge i_nrst)
        if (!i_nrst)
            exp_r <= {8'h00, 1'b1, 1'b0, 1'b0};
        else
            exp_r <= model(bus);
    // compare at mid-cycle, where everything has settled
    always @(negedge i_clk)
        if (chk_en)
        begin
            chk_sel({8'h00, exp_r[10:3]}, {8'h00, o_sel});
            chk_bit(exp_r[2], o_rd_wr, "rd_wr");
            chk_bit(exp_r[1], o_drive, "drive");
            chk_bit(exp_r[0], o_ill, "overlap");
            if ((|exp_r[8:3]) || ((|exp_r[10:9]) && exp_r[2]))
                hits_m++;
        end
    initial
    begin
        #(25 * 6000);
        fails++;
        end_of_test();
    end
    initial
    begin
        repeat (10) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        chk_en <= 1'b1;
        // every window and vector under each qualifier; adapters keep a7/a8 high
        for (int i = 0; i < 11; i++)
            for (int k = 0; k < 4; k++)
            begin
                @(posedge i_clk);
                bus <= {tbl[i], k != 1, i[0], 1'b1, k == 2, k == 3};
            end
        $display("directed done");
        for (int n = 0; n < 3000; n++)
        begin
            @(posedge i_clk);
            r = xr();
            bus <= r[20:0];
        end
        $display("random done");
        @(posedge i_clk);
        i_nrst <= 1'b0;
        bus <= '0;
        repeat (2) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (4) @(posedge i_clk);
        $display("reset done");
        #1;
        chk_sel(hits_m[15:0], hits);
        end_of_test();
    end
endmodule
`default_nettype wire
